//--- core/mgb_bank.sv
// Top of the general-purpose pad bank with its AHB-Lite register slave.
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each pad is set to input, output or alternate function on its own.
// - An input pad is read only and reports its present pad level.
// - An output pad takes writes of its driven level and reads them back.
// - An alternate-function pad is driven by its owning internal function only.
// - Ten primary pads are always available for general-purpose use.
// - Shared pads start in their interface role and can be switched to GPIO.
// - Primary pads one to ten also offer an I2C role through their function setting.
// - Any input pad can raise an interrupt on its level or on an edge.
// - Only pads one, four, five and eight can wake the module from sleep.
// - An output pad drives both high and low, needing no external pull-up.
module mgb_bank #(
  parameter int unsigned NUM_PADS    = mgb_pkg::NUM_PADS,
  parameter int unsigned NUM_PRIMARY = mgb_pkg::NUM_PRIMARY
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Pads
  input  wire logic [NUM_PADS-1:0]    pad_in,
  output logic      [NUM_PADS-1:0]    pad_out,
  output logic      [NUM_PADS-1:0]    pad_oe,
  // Internal alternate functions
  input  wire logic [NUM_PADS-1:0]    fn_out,
  input  wire logic [NUM_PADS-1:0]    fn_oe,
  input  wire logic [NUM_PRIMARY-1:0] i2c_pull_low,
  output logic      [NUM_PADS-1:0]    pad_level,
  // Events
  output logic                        irq,
  output logic                        wake_req
);

  import mgb_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [NUM_PADS-1:0]    dir;
  logic [NUM_PADS-1:0]    alt;
  logic [NUM_PADS-1:0]    out_val;
  logic [NUM_PRIMARY-1:0] i2c_sel;
  logic [NUM_PADS-1:0]    int_stat;
  logic [NUM_PADS-1:0]    int_en;
  logic [NUM_PADS-1:0]    int_edge;
  logic [NUM_PADS-1:0]    int_pol;
  logic [NUM_PADS-1:0]    wake_en;
  logic [NUM_PADS-1:0]    level_prev;
  logic [NUM_PADS-1:0]    in_mode;
  logic [NUM_PADS-1:0]    int_hit;
  logic [NUM_PADS-1:0]    int_clr;
  logic [NUM_PADS-1:0]    next_pad_out;
  logic [NUM_PADS-1:0]    next_pad_oe;
  logic [NUM_PADS-1:0]    wr_bits;
  logic [31:0]            next_hrdata;
  logic                   addr_take;
  logic                   wr_pend;
  logic [OFFS_W-1:0]      wr_offs;

  // ----------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------
  mgb_pad_sync #(
    .WIDTH      (NUM_PADS)
  ) u_sync (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .async_in   (pad_in),
    .level      (pad_level),
    .level_prev (level_prev)
  );

  // ----------------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------------
  // The slave never inserts wait states and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wr_bits   = hwdata[NUM_PADS-1:0];

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_pend <= 1'b0;
      wr_offs <= '0;
    end
    else
    begin
      wr_pend <= addr_take && hwrite;
      wr_offs <= haddr[OFFS_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Read data is captured at the address phase and stands in the data phase.
  always_comb
  begin
    next_hrdata = 32'h0;
    unique case (haddr[OFFS_W-1:0])
      OFFS_DIR:      next_hrdata[NUM_PADS-1:0] = dir;
      OFFS_ALT:      next_hrdata[NUM_PADS-1:0] = alt;
      OFFS_OUT:      next_hrdata[NUM_PADS-1:0] = out_val;
      OFFS_IN:       next_hrdata[NUM_PADS-1:0] = pad_level;
      OFFS_I2C_SEL:  next_hrdata[NUM_PRIMARY-1:0] = i2c_sel;
      OFFS_INT_STAT: next_hrdata[NUM_PADS-1:0] = int_stat;
      OFFS_INT_EN:   next_hrdata[NUM_PADS-1:0] = int_en;
      OFFS_INT_EDGE: next_hrdata[NUM_PADS-1:0] = int_edge;
      OFFS_INT_POL:  next_hrdata[NUM_PADS-1:0] = int_pol;
      OFFS_WAKE_EN:  next_hrdata[NUM_PADS-1:0] = wake_en;
      OFFS_DRIVE:    next_hrdata[NUM_PADS-1:0] = pad_oe;
      default:       next_hrdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      hrdata <= 32'h0;
    end
    else if (addr_take && !hwrite)
    begin
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------------
  // Pad role registers
  // ----------------------------------------------------------------------
  // A pad is an output when dir is set and alt clear, an input when both are clear.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      dir <= RST_DIR;
    end
    else if (wr_pend && (wr_offs == OFFS_DIR))
    begin
      dir <= wr_bits;
    end
  end

  // Primary pads reset to GPIO; shared pads reset to their interface.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      alt <= RST_ALT;
    end
    else if (wr_pend && (wr_offs == OFFS_ALT))
    begin
      alt <= wr_bits;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      i2c_sel <= RST_I2C_SEL;
    end
    else if (wr_pend && (wr_offs == OFFS_I2C_SEL))
    begin
      i2c_sel <= wr_bits[NUM_PRIMARY-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Output value register
  // ----------------------------------------------------------------------
  // Set and clear offsets let software change single pads without a read.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      out_val <= RST_OUT;
    end
    else if (wr_pend)
    begin
      unique case (wr_offs)
        OFFS_OUT:     out_val <= wr_bits;
        OFFS_OUT_SET: out_val <= out_val | wr_bits;
        OFFS_OUT_CLR: out_val <= out_val & ~wr_bits;
        default:      out_val <= out_val;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------------
  generate
    for (genvar p = 0; p < NUM_PADS; p++)
    begin : g_drive
      if (p < NUM_PRIMARY)
      begin : g_primary
        always_comb
        begin
          if (!alt[p])
          begin
            next_pad_out[p] = out_val[p];
            next_pad_oe[p]  = dir[p];
          end
          else if (i2c_sel[p])
          begin
            // The I2C role only ever pulls low, the line is open-drain.
            next_pad_out[p] = 1'b0;
            next_pad_oe[p]  = i2c_pull_low[p];
          end
          else
          begin
            next_pad_out[p] = fn_out[p];
            next_pad_oe[p]  = fn_oe[p];
          end
        end
      end
      else
      begin : g_shared
        always_comb
        begin
          if (!alt[p])
          begin
            next_pad_out[p] = out_val[p];
            next_pad_oe[p]  = dir[p];
          end
          else
          begin
            next_pad_out[p] = fn_out[p];
            next_pad_oe[p]  = fn_oe[p];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pad_out <= '0;
      pad_oe  <= '0;
    end
    else
    begin
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      int_en <= RST_INT_EN;
    end
    else if (wr_pend && (wr_offs == OFFS_INT_EN))
    begin
      int_en <= wr_bits;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      int_edge <= RST_INT_EDGE;
      int_pol  <= RST_INT_POL;
    end
    else if (wr_pend)
    begin
      if (wr_offs == OFFS_INT_EDGE)
      begin
        int_edge <= wr_bits;
      end
      if (wr_offs == OFFS_INT_POL)
      begin
        int_pol <= wr_bits;
      end
    end
  end

  // Wake enables exist only for the wake-capable pads.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wake_en <= RST_WAKE_EN;
    end
    else if (wr_pend && (wr_offs == OFFS_WAKE_EN))
    begin
      wake_en <= wr_bits & WAKE_CAPABLE;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt detection
  // ----------------------------------------------------------------------
  // Only pads in input role raise events; level mode matches polarity,
  // edge mode sees a rising edge for high polarity and falling for low.
  assign in_mode = ~dir & ~alt;

  generate
    for (genvar p = 0; p < NUM_PADS; p++)
    begin : g_detect
      always_comb
      begin
        if (int_edge[p])
        begin
          int_hit[p] = in_mode[p] && (pad_level[p] == int_pol[p]) &&
                       (level_prev[p] != int_pol[p]);
        end
        else
        begin
          int_hit[p] = in_mode[p] && (pad_level[p] == int_pol[p]);
        end
      end
    end
  endgenerate

  assign int_clr = (wr_pend && (wr_offs == OFFS_INT_CLR)) ? wr_bits : '0;

  // A new event in the clearing cycle keeps its flag set.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      int_stat <= '0;
    end
    else
    begin
      int_stat <= (int_stat & ~int_clr) | int_hit;
    end
  end

  assign irq      = |(int_stat & int_en);
  assign wake_req = |(int_stat & wake_en & WAKE_CAPABLE);

  // Whole-word transfers leave hsize and the upper address bits unused.
  logic unused_bus;
  assign unused_bus = ^{hsize, haddr[31:OFFS_W], hwdata[31:NUM_PADS], htrans[0]};

endmodule

`default_nettype wire

//--- core/mgb_pad_sync.sv
// Two-stage synchroniser with a delayed copy for edge detection.
`timescale 1ns/1ps
`default_nettype none

module mgb_pad_sync #(
  parameter int unsigned WIDTH = 27
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Asynchronous pad levels
  input  wire logic [WIDTH-1:0] async_in,
  // Synchronised level and its value one cycle earlier
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] level_prev
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      meta       <= '0;
      level      <= '0;
      level_prev <= '0;
    end
    else
    begin
      meta       <= async_in;
      level      <= meta;
      level_prev <= level;
    end
  end

endmodule

`default_nettype wire

//--- core/mgb_pkg.sv
// Package of register map, field layouts and reset values for the pad bank.
package mgb_pkg;

  // ----------------------------------------------------------------------
  // Bank geometry
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_PADS    = 27;
  localparam int unsigned NUM_PRIMARY = 10;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned OFFS_W      = 8;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [OFFS_W-1:0] OFFS_DIR       = 8'h00;
  localparam logic [OFFS_W-1:0] OFFS_ALT       = 8'h04;
  localparam logic [OFFS_W-1:0] OFFS_OUT       = 8'h08;
  localparam logic [OFFS_W-1:0] OFFS_OUT_SET   = 8'h0c;
  localparam logic [OFFS_W-1:0] OFFS_OUT_CLR   = 8'h10;
  localparam logic [OFFS_W-1:0] OFFS_IN        = 8'h14;
  localparam logic [OFFS_W-1:0] OFFS_I2C_SEL   = 8'h18;
  localparam logic [OFFS_W-1:0] OFFS_INT_STAT  = 8'h1c;
  localparam logic [OFFS_W-1:0] OFFS_INT_CLR   = 8'h20;
  localparam logic [OFFS_W-1:0] OFFS_INT_EN    = 8'h24;
  localparam logic [OFFS_W-1:0] OFFS_INT_EDGE  = 8'h28;
  localparam logic [OFFS_W-1:0] OFFS_INT_POL   = 8'h2c;
  localparam logic [OFFS_W-1:0] OFFS_WAKE_EN   = 8'h30;
  localparam logic [OFFS_W-1:0] OFFS_DRIVE     = 8'h34;

  // ----------------------------------------------------------------------
  // Pad positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned WAKE_PAD_ONE   = 0;
  localparam int unsigned WAKE_PAD_FOUR  = 3;
  localparam int unsigned WAKE_PAD_FIVE  = 4;
  localparam int unsigned WAKE_PAD_EIGHT = 7;

  localparam logic [NUM_PADS-1:0] WAKE_CAPABLE =
    (27'h1 << WAKE_PAD_ONE) | (27'h1 << WAKE_PAD_FOUR) |
    (27'h1 << WAKE_PAD_FIVE) | (27'h1 << WAKE_PAD_EIGHT);

  // Shared pads start in their interface role, primary pads as GPIO.
  localparam logic [NUM_PADS-1:0] RST_ALT      = 27'h7fffc00;
  localparam logic [NUM_PADS-1:0] RST_DIR      = 27'h0;
  localparam logic [NUM_PADS-1:0] RST_OUT      = 27'h0;
  localparam logic [NUM_PADS-1:0] RST_INT_EN   = 27'h0;
  localparam logic [NUM_PADS-1:0] RST_INT_EDGE = 27'h0;
  localparam logic [NUM_PADS-1:0] RST_INT_POL  = 27'h0;
  localparam logic [NUM_PADS-1:0] RST_WAKE_EN  = 27'h0;
  localparam logic [NUM_PRIMARY-1:0] RST_I2C_SEL = 10'h0;

  // ----------------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

//--- tb/mgb_bank_chk.sv
// Port-level assertions for the pad bank.
`timescale 1ns/1ps
`default_nettype none
module mgb_bank_chk #(
  parameter int unsigned NUM_PADS = mgb_pkg::NUM_PADS
) (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                reset,
  // Register bus
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // Pads and functions
  input wire logic [NUM_PADS-1:0] pad_in,
  input wire logic [NUM_PADS-1:0] pad_out,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [NUM_PADS-1:0] fn_out,
  input wire logic [NUM_PADS-1:0] fn_oe,
  input wire logic [NUM_PADS-1:0] pad_level,
  // Events
  input wire logic                irq,
  input wire logic                wake_req
);
  import mgb_pkg::*;
  logic [1:0] up_cnt;
  logic       no_wr;
  wire logic  take = hsel && hready && htrans == HTRANS_NONSEQ;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Saturating count of edges since release keeps history checks off reset values.
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      up_cnt <= 2'h0;
    else if (up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;

  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      no_wr <= 1'b1;
    else if (take && hwrite)
      no_wr <= 1'b0;

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_sync_two: assert property (up_cnt == 2'h3 |-> pad_level == $past(pad_in, 2))
    else $error("pad level not two cycles behind pad input");
  a_shared_fn: assert property (up_cnt != 2'h0 && no_wr |->
    pad_oe[NUM_PADS-1:10] == $past(fn_oe[NUM_PADS-1:10]) &&
    pad_out[NUM_PADS-1:10] == $past(fn_out[NUM_PADS-1:10]))
    else $error("shared pad not driven by its function");
  a_prim_input: assert property (up_cnt != 2'h0 && no_wr |-> pad_oe[9:0] == 10'h0)
    else $error("primary pad driven before configuration");
  a_events_quiet: assert property (no_wr |-> !irq && !wake_req)
    else $error("event raised before configuration");
  a_rdata_hold: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
    else $error("read data changed without a read");
  a_in_read: assert property ($past(take && !hwrite && haddr[7:0] == OFFS_IN) |->
    hrdata[NUM_PADS-1:0] == $past(pad_level))
    else $error("input register read differs from pad level");
  a_drive_read: assert property ($past(take && !hwrite && haddr[7:0] == OFFS_DRIVE) |->
    hrdata[NUM_PADS-1:0] == $past(pad_oe))
    else $error("drive register read differs from pad enables");
endmodule
`default_nettype wire

//--- tb/mgb_board.sv
// Board-side model of the devices wired to the pads.
`timescale 1ns/1ps
`default_nettype none
module mgb_board #(
  parameter int unsigned          NUM_PADS  = 27,
  parameter logic [NUM_PADS-1:0]  BOOT_MASK = 27'h0260571
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset,
  // Bank drivers and board requests
  input  wire logic [NUM_PADS-1:0] pad_out,
  input  wire logic [NUM_PADS-1:0] pad_oe,
  input  wire logic [NUM_PADS-1:0] ext_val,
  input  wire logic [NUM_PADS-1:0] ext_en,
  // Resolved pad levels
  output logic      [NUM_PADS-1:0] pad_in
);
  logic [NUM_PADS-1:0] float_val;
  logic [NUM_PADS-1:0] board_val;

  // Undriven pads toggle every cycle so a stale level never passes as valid.
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      float_val <= '0;
    else
      float_val <= ~float_val;

  // Boot-sensitive pads are kept low while the module powers on.
  assign board_val = reset ? (ext_val & ~BOOT_MASK) : ext_val;
  // No pull-ups: an enabled bank driver sets either level itself.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & board_val) |
                  (~pad_oe & ~ext_en & float_val);
endmodule
`default_nettype wire

//--- tb/module_gpio_bank_test.sv
// Self-checking testbench of the pad bank.
`timescale 1ns/1ps
`default_nettype none
module module_gpio_bank_test;
  import mgb_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} mgb_row_s;
  logic        clk_sys = 1'b0;
  logic        reset, hsel, hwrite, hready, hreadyout, hresp, irq, wake_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [26:0] pad_in, pad_out, pad_oe, fn_out, fn_oe, pad_level, ext_val, ext_en;
  logic [9:0]  i2c_pull_low;
  int          n_checks = 0;
  int          n_mismatch = 0;
  mgb_row_s    rows [0:19] = '{
    '{1'b1, OFFS_OUT, 32'h155, 32'h155}, '{1'b1, OFFS_OUT_SET, 32'h0aa, 32'h0},
    '{1'b1, OFFS_OUT_CLR, 32'h1, 32'h0}, '{1'b0, OFFS_OUT, 32'h0, 32'h1fe},
    '{1'b1, OFFS_DIR, '1, 32'h7ffffff}, '{1'b1, OFFS_ALT, '1, 32'h7ffffff},
    '{1'b1, OFFS_I2C_SEL, '1, 32'h3ff}, '{1'b1, OFFS_WAKE_EN, '1, 32'h99},
    '{1'b1, OFFS_INT_EDGE, '1, 32'h7ffffff}, '{1'b1, OFFS_INT_POL, '1, 32'h7ffffff},
    '{1'b1, OFFS_INT_EN, '1, 32'h7ffffff}, '{1'b1, 8'h3c, '1, 32'h0},
    '{1'b1, OFFS_ALT, 32'h7fffc00, 32'h7fffc00}, '{1'b1, OFFS_I2C_SEL, 32'h0, 32'h0},
    '{1'b1, OFFS_WAKE_EN, 32'h0, 32'h0}, '{1'b1, OFFS_INT_EN, 32'h0, 32'h0},
    '{1'b1, OFFS_INT_EDGE, 32'h0, 32'h0}, '{1'b1, OFFS_INT_POL, 32'h0, 32'h0},
    '{1'b1, OFFS_DIR, 32'h0, 32'h0}, '{1'b1, OFFS_INT_CLR, '1, 32'h0}};

  always #5 clk_sys = ~clk_sys;
  assign hready = hreadyout;

  mgb_bank dut_u (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .fn_out(fn_out), .fn_oe(fn_oe),
    .i2c_pull_low(i2c_pull_low), .pad_level(pad_level), .irq(irq), .wake_req(wake_req));
  mgb_board board_u (.clk_sys(clk_sys), .reset(reset), .pad_out(pad_out),
    .pad_oe(pad_oe), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_rdy();
    int i;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1)
    begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    {hsel, hwrite, haddr, htrans, hwdata, fn_out, fn_oe, i2c_pull_low} <= '0;
    hsize <= 3'h2;
    ext_val <= '1;
    ext_en <= '1;
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    settle(2);
    check(32'(pad_oe), 32'h0);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    wr(OFFS_DIR, 32'h3ff);
    wr(OFFS_OUT, 32'h201);
    settle(3);
    check(32'(pad_oe[9:0]), 32'h3ff);
    check(32'(pad_out[9:0]), 32'h201);
    rd_chk(OFFS_IN, 32'h7fffe01);
    rd_chk(OFFS_DRIVE, 32'h3ff);
    fn_oe <= '1;
    fn_out <= 27'h2aaaaaa;
    settle(2);
    check(32'(pad_oe[26:10]), 32'h1ffff);
    check(32'(pad_out[26:10]), 32'h0aaaa);
    check(32'(pad_out[9:0]), 32'h201);
    @(posedge clk_sys);
    fn_oe <= '0;
    wr(OFFS_DIR, 32'h0);
    wr(OFFS_ALT, 32'h0);
    ext_val <= 27'h5a5a5a5;
    settle(1);
    check(32'(pad_oe), 32'h0);
    check(32'(pad_level), 32'h7ffffff);
    settle(1);
    check(32'(pad_level), 32'h5a5a5a5);
    rd_chk(OFFS_IN, 32'h5a5a5a5);
    wr(OFFS_ALT, 32'h7fffc01);
    wr(OFFS_I2C_SEL, 32'h1);
    i2c_pull_low <= 10'h1;
    settle(2);
    check(32'({pad_oe[0], pad_out[0]}), 32'h2);
    @(posedge clk_sys);
    i2c_pull_low <= 10'h0;
    settle(2);
    check(32'(pad_oe[0]), 32'h0);
    wr(OFFS_ALT, 32'h7fffc00);
    ext_val <= '0;
    wr(OFFS_INT_EDGE, '1);
    wr(OFFS_INT_POL, '1);
    wr(OFFS_INT_CLR, '1);
    wr(OFFS_INT_EN, 32'h2);
    ext_val <= 27'h00e;
    settle(4);
    rd_chk(OFFS_INT_STAT, 32'he);
    check(32'({irq, wake_req}), 32'h2);
    wr(OFFS_WAKE_EN, '1);
    settle(1);
    check(32'(wake_req), 32'h1);
    wr(OFFS_INT_CLR, 32'h8);
    settle(1);
    check(32'({irq, wake_req}), 32'h2);
    wr(OFFS_INT_EN, 32'h0);
    settle(1);
    check(32'(irq), 32'h0);
    wr(OFFS_INT_EDGE, 32'h0);
    wr(OFFS_INT_CLR, 32'he);
    rd_chk(OFFS_INT_STAT, 32'he);
    wr(OFFS_INT_EDGE, '1);
    wr(OFFS_INT_POL, 32'h0);
    wr(OFFS_INT_CLR, '1);
    ext_val <= '0;
    settle(4);
    rd_chk(OFFS_INT_STAT, 32'he);
    check(32'({irq, wake_req}), 32'h1);
    @(posedge clk_sys);
    reset <= 1'b1;
    settle(2);
    @(posedge clk_sys);
    reset <= 1'b0;
    settle(1);
    check(32'({pad_oe, irq, wake_req}), 32'h0);
    rd_chk(OFFS_ALT, 32'h7fffc00);
    rd_chk(OFFS_WAKE_EN, 32'h0);
    rd_chk(OFFS_INT_EN, 32'h0);
    rd_chk(OFFS_DIR, 32'h0);
    summarize();
  end
endmodule

bind mgb_bank mgb_bank_chk #(.NUM_PADS(NUM_PADS)) chk_u (.clk_sys(clk_sys),
  .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .fn_out(fn_out),
  .fn_oe(fn_oe), .pad_level(pad_level), .irq(irq), .wake_req(wake_req));
`default_nettype wire
